/* File: pups_pkg.sv */
package pups_pkg;
	// Core clock rate
	localparam int CLK_MHZ = 100;
	// Fuse load, wake and debounce times in microseconds
	localparam int FUSE_LOAD_US = 600;
	localparam int WAKE_US = 800;
	localparam int DEBOUNCE_US = 1000;
	// Cycles lost in the pin synchroniser and state entry
	localparam int SYNC_LAT = 5;
	// Sequencer time base values in microseconds
	localparam int TB_US0 = 30;
	localparam int TB_US1 = 120;
	localparam int TB_US2 = 250;
	localparam int TB_US3 = 500;
	localparam int CNT_W = 17;
	// Output indices: three switchers, linear regulator, power good, MCU reset
	localparam int N_OUT = 6;
	localparam int N_REG = 4;
	localparam int OUT_POWER_GOOD_PIN = 4;
	localparam int OUT_RESET = 5;
	localparam logic [7:0] SEQ_OFF = 8'h00;
	localparam logic [1:0] TB_30 = 2'h0;
	localparam logic [1:0] TB_120 = 2'h1;
	localparam logic [1:0] TB_250 = 2'h2;
	// Device configuration port addresses
	localparam logic [3:0] CFG_TBASE = 4'h6;
	localparam logic [3:0] CFG_LPM = 4'h7;
	localparam logic [3:0] CFG_STBY = 4'h8;
	// Host Wishbone register byte offsets
	localparam logic [7:0] WB_CTRL = 8'h00;
	localparam logic [7:0] WB_CFG = 8'h04;
	localparam logic [7:0] WB_STAT = 8'h08;
	localparam logic [7:0] WB_IRQ = 8'h0C;
	localparam logic [7:0] WB_MASK = 8'h10;
	// Field positions
	localparam int CTRL_POWER_ON_PIN = 0;
	localparam int CTRL_STBY = 1;
	localparam int CFG_ADDR_LSB = 8;
	localparam int STAT_RESET = 6;
	localparam int STAT_RUN = 7;
	localparam int STAT_FUSE = 8;
	localparam int IRQ_PWRUP = 0;
	localparam int IRQ_RUN = 1;
	localparam int IRQ_W = 2;
	// Sequencer states
	typedef enum logic [2:0] {S_FUSE, S_OFF, S_WAKE, S_SEQ, S_RUN, S_STBY} pups_state_t;
endpackage

/* File: pups_if.sv */
`timescale 1ns/1ps
`default_nettype none
interface pups_if;
	logic powerOnPin;
	logic standbyReq;
	logic cfgWe;
	logic [3:0] cfgAddr;
	logic [7:0] cfgWdata;
	logic [pups_pkg::N_OUT-1:0] outEnable;
	logic mcuResetN;
	logic runState;
	logic pwrupIrq;
	logic fuseLoadDone;
	// Regulator device end
	modport dev (
		input powerOnPin, standbyReq, cfgWe, cfgAddr, cfgWdata,
		output outEnable, mcuResetN, runState, pwrupIrq, fuseLoadDone
	);
	// Host controller end
	modport host (
		output powerOnPin, standbyReq, cfgWe, cfgAddr, cfgWdata,
		input outEnable, mcuResetN, runState, pwrupIrq, fuseLoadDone
	);
endinterface
`default_nettype wire

/* File: pups_slot_timer.sv */
`timescale 1ns/1ps
`default_nettype none
module pups_slot_timer #(
	parameter int CW = 17
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic run,
	input wire logic [CW-1:0] period,
	output logic tick
);
	logic [CW-1:0] cnt_r;
	logic [CW-1:0] cnt_nxt;
	logic tick_nxt;

	// Free count while running, one pulse per period
	always_comb begin
		cnt_nxt = '0;
		tick_nxt = 1'b0;
		if (run) begin
			if (cnt_r >= period - CW'(1)) begin
				tick_nxt = 1'b1;
			end else begin
				cnt_nxt = cnt_r + CW'(1);
			end
		end
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			cnt_r <= '0;
			tick <= 1'b0;
		end else begin
			cnt_r <= cnt_nxt;
			tick <= tick_nxt & run;
		end
	end
endmodule
`default_nettype wire

/* File: pups_device.sv */
// The implementer's own choices: the placing of the registers and the Wishbone slave port.
`timescale 1ns/1ps
`default_nettype none
module pups_device #(
	parameter int FUSE_CYC = pups_pkg::FUSE_LOAD_US * pups_pkg::CLK_MHZ,
	parameter int WAKE_CYC = pups_pkg::WAKE_US * pups_pkg::CLK_MHZ,
	parameter int DBNC_CYC = pups_pkg::DEBOUNCE_US * pups_pkg::CLK_MHZ,
	parameter int TB0_CYC = pups_pkg::TB_US0 * pups_pkg::CLK_MHZ,
	parameter int TB1_CYC = pups_pkg::TB_US1 * pups_pkg::CLK_MHZ,
	parameter int TB2_CYC = pups_pkg::TB_US2 * pups_pkg::CLK_MHZ,
	parameter int TB3_CYC = pups_pkg::TB_US3 * pups_pkg::CLK_MHZ
) (
	input wire logic clk,
	input wire logic nrst,
	pups_if.dev link,
	input wire logic [pups_pkg::N_OUT-1:0][7:0] seqFuse,
	input wire logic [1:0] tbaseFuse,
	input wire logic edgeModeFuse,
	input wire logic ovShdnFuse,
	input wire logic ovloEnable,
	input wire logic supplyOk,
	input wire logic overVoltage,
	input wire logic overTemp,
	input wire logic trimFail,
	input wire logic fuseFail,
	input wire logic selftestFail,
	output logic lowPowerOff
);
	localparam int CW = pups_pkg::CNT_W;

	pups_pkg::pups_state_t state_r, state_nxt;
	logic [CW-1:0] cnt_r, cnt_nxt;
	logic [7:0] slot_r, slot_nxt;
	logic [pups_pkg::N_OUT-1:0] en_r, en_nxt;
	logic [pups_pkg::N_OUT-1:0][7:0] seq_r, seq_nxt;
	logic [1:0] tbase_r, tbase_nxt;
	logic lpm_r, lpm_nxt;
	logic [pups_pkg::N_REG-1:0] stbyMask_r, stbyMask_nxt;
	logic arm_r, arm_nxt;
	logic irq_r, irq_nxt;
	logic fuseDone_r, fuseDone_nxt;
	logic pinS1_r, pinS2_r, pinPrev_r;
	logic [CW-1:0] tbCyc;
	logic slotTick;
	logic seqRun;
	logic evValid;
	logic powerEvt;
	logic [7:0] maxCode;
	logic [pups_pkg::N_OUT-1:0] slotHit;
	logic [pups_pkg::N_REG-1:0] wantOn;
	logic lastDone;

	// Time base decode
	always_comb begin
		case (tbase_r)
			pups_pkg::TB_30: tbCyc = CW'(TB0_CYC);
			pups_pkg::TB_120: tbCyc = CW'(TB1_CYC);
			pups_pkg::TB_250: tbCyc = CW'(TB2_CYC);
			default: tbCyc = CW'(TB3_CYC);
		endcase
	end

	assign seqRun = (state_r == pups_pkg::S_SEQ);

	// Slot interval generator, restarted on each sequence
	pups_slot_timer #(
		.CW(CW)
	) u_slot_timer (
		.clk(clk),
		.nrst(nrst),
		.run(seqRun),
		.period(tbCyc),
		.tick(slotTick)
	);

	// Per-output slot match and highest code in use
	// The tick counts in its own cycle, so slot k lands k intervals after slot 0
	genvar gi;
	generate
		for (gi = 0; gi < pups_pkg::N_OUT; gi++) begin : g_hit
			assign slotHit[gi] = (seq_r[gi] != pups_pkg::SEQ_OFF) &&
				({1'b0, seq_r[gi]} <= {1'b0, slot_r} + {8'h00, slotTick} + 9'h001);
		end
		for (gi = 0; gi < pups_pkg::N_REG; gi++) begin : g_want
			assign wantOn[gi] = (seq_r[gi] != pups_pkg::SEQ_OFF);
		end
	endgenerate

	always_comb begin
		maxCode = pups_pkg::SEQ_OFF;
		for (int i = 0; i < pups_pkg::N_OUT; i++) begin
			if (seq_r[i] > maxCode) begin
				maxCode = seq_r[i];
			end
		end
	end

	// All programmed slots reached; zero codes mean slave mode
	assign lastDone = (maxCode == pups_pkg::SEQ_OFF) ||
		({1'b0, slot_r} + 9'h001 >= {1'b0, maxCode});

	// Power-up validity conditions
	assign evValid = supplyOk && !overTemp && !trimFail && !fuseFail && !selftestFail &&
		(!overVoltage || !ovloEnable || !ovShdnFuse);

	// Level or debounced edge event
	assign powerEvt = edgeModeFuse ?
		(arm_r && !pinS2_r && (cnt_r >= CW'(DBNC_CYC - 1))) :
		pinS2_r;

	// Sequencer next state
	always_comb begin
		state_nxt = state_r;
		cnt_nxt = cnt_r;
		slot_nxt = slot_r;
		en_nxt = en_r;
		seq_nxt = seq_r;
		tbase_nxt = tbase_r;
		lpm_nxt = lpm_r;
		stbyMask_nxt = stbyMask_r;
		arm_nxt = arm_r;
		irq_nxt = 1'b0;
		fuseDone_nxt = fuseDone_r;
		case (state_r)
			pups_pkg::S_FUSE: begin
				cnt_nxt = cnt_r + CW'(1);
				if (cnt_r >= CW'(FUSE_CYC - 1)) begin
					fuseDone_nxt = 1'b1;
					cnt_nxt = '0;
					state_nxt = pups_pkg::S_OFF;
				end
			end
			pups_pkg::S_OFF: begin
				en_nxt = '0;
				seq_nxt = seqFuse;
				tbase_nxt = tbaseFuse;
				if (pinPrev_r && !pinS2_r) begin
					arm_nxt = 1'b1;
					cnt_nxt = '0;
				end else if (pinS2_r) begin
					arm_nxt = 1'b0;
					cnt_nxt = '0;
				end else if (arm_r) begin
					cnt_nxt = cnt_r + CW'(1);
				end
				if (powerEvt && evValid) begin
					arm_nxt = 1'b0;
					cnt_nxt = '0;
					slot_nxt = '0;
					state_nxt = lpm_r ? pups_pkg::S_SEQ : pups_pkg::S_WAKE;
				end
			end
			pups_pkg::S_WAKE: begin
				cnt_nxt = cnt_r + CW'(1);
				if (cnt_r >= CW'(WAKE_CYC - pups_pkg::SYNC_LAT)) begin
					cnt_nxt = '0;
					state_nxt = selftestFail ? pups_pkg::S_OFF : pups_pkg::S_SEQ;
				end
			end
			pups_pkg::S_SEQ: begin
				en_nxt = en_r | slotHit;
				if (slotTick) begin
					slot_nxt = slot_r + 8'h01;
				end
				if (!evValid) begin
					en_nxt = '0;
					state_nxt = pups_pkg::S_OFF;
				end else if (lastDone) begin
					en_nxt[pups_pkg::OUT_RESET] = 1'b1;
					state_nxt = pups_pkg::S_RUN;
				end
			end
			pups_pkg::S_RUN: begin
				en_nxt[pups_pkg::OUT_RESET] = 1'b1;
				if (!edgeModeFuse && !pinS2_r) begin
					en_nxt = '0;
					state_nxt = pups_pkg::S_OFF;
				end else if (link.standbyReq) begin
					en_nxt[pups_pkg::N_REG-1:0] = en_r[pups_pkg::N_REG-1:0] & stbyMask_r;
					state_nxt = pups_pkg::S_STBY;
				end
			end
			pups_pkg::S_STBY: begin
				if (!link.standbyReq) begin
					if (|(wantOn & ~en_r[pups_pkg::N_REG-1:0])) begin
						slot_nxt = '0;
						arm_nxt = 1'b1;
						state_nxt = pups_pkg::S_SEQ;
					end else begin
						irq_nxt = 1'b1;
						state_nxt = pups_pkg::S_RUN;
					end
				end
			end
			default: begin
				state_nxt = pups_pkg::S_OFF;
			end
		endcase
		// Configuration writes while the system is on
		if (link.cfgWe && (state_r == pups_pkg::S_RUN || state_r == pups_pkg::S_STBY)) begin
			if (link.cfgAddr < 4'(pups_pkg::N_OUT)) begin
				seq_nxt[link.cfgAddr] = link.cfgWdata;
			end else if (link.cfgAddr == pups_pkg::CFG_TBASE) begin
				tbase_nxt = link.cfgWdata[1:0];
			end else if (link.cfgAddr == pups_pkg::CFG_LPM) begin
				lpm_nxt = link.cfgWdata[0];
			end else if (link.cfgAddr == pups_pkg::CFG_STBY) begin
				stbyMask_nxt = link.cfgWdata[pups_pkg::N_REG-1:0];
			end
		end
		// Sequence entered from standby flags completion on exit
		if (state_r == pups_pkg::S_SEQ && state_nxt == pups_pkg::S_RUN) begin
			irq_nxt = arm_r;
			arm_nxt = 1'b0;
		end
	end

	// State registers; reset models the supply crossing the threshold
	always_ff @(posedge clk) begin
		if (!nrst) begin
			state_r <= pups_pkg::S_FUSE;
			cnt_r <= '0;
			slot_r <= '0;
			en_r <= '0;
			seq_r <= '0;
			tbase_r <= pups_pkg::TB_30;
			lpm_r <= 1'b0;
			stbyMask_r <= '0;
			arm_r <= 1'b0;
			irq_r <= 1'b0;
			fuseDone_r <= 1'b0;
			pinS1_r <= 1'b0;
			pinS2_r <= 1'b0;
			pinPrev_r <= 1'b0;
		end else begin
			state_r <= state_nxt;
			cnt_r <= cnt_nxt;
			slot_r <= slot_nxt;
			en_r <= en_nxt;
			seq_r <= seq_nxt;
			tbase_r <= tbase_nxt;
			lpm_r <= lpm_nxt;
			stbyMask_r <= stbyMask_nxt;
			arm_r <= arm_nxt;
			irq_r <= irq_nxt;
			fuseDone_r <= fuseDone_nxt;
			pinS1_r <= link.powerOnPin;
			pinS2_r <= pinS1_r;
			pinPrev_r <= pinS2_r;
		end
	end

	// Outputs
	assign link.outEnable = en_r;
	assign link.mcuResetN = en_r[pups_pkg::OUT_RESET];
	assign link.runState = (state_r == pups_pkg::S_RUN);
	assign link.pwrupIrq = irq_r;
	assign link.fuseLoadDone = fuseDone_r;
	assign lowPowerOff = lpm_r;
endmodule
`default_nettype wire

/* File: pups_host.sv */
`timescale 1ns/1ps
`default_nettype none
module pups_host (
	input wire logic clk,
	input wire logic nrst,
	input wire logic [7:0] wb_adr_i,
	input wire logic [31:0] wb_dat_i,
	output logic [31:0] wb_dat_o,
	input wire logic wb_we_i,
	input wire logic [3:0] wb_sel_i,
	input wire logic wb_cyc_i,
	input wire logic wb_stb_i,
	output logic wb_ack_o,
	output logic irq,
	pups_if.host link
);
	logic [1:0] ctrl_r, ctrl_nxt;
	logic cfgWe_r, cfgWe_nxt;
	logic [3:0] cfgAddr_r, cfgAddr_nxt;
	logic [7:0] cfgData_r, cfgData_nxt;
	logic [pups_pkg::IRQ_W-1:0] stat_r, stat_nxt;
	logic [pups_pkg::IRQ_W-1:0] mask_r, mask_nxt;
	logic ack_r, ack_nxt;
	logic [31:0] rdat_r, rdat_nxt;
	logic runPrev_r;
	logic req;
	logic wr;
	logic [pups_pkg::IRQ_W-1:0] evt;
	logic [31:0] rmux;

	assign req = wb_cyc_i && wb_stb_i;
	// Writes commit on the edge where the master sees ack
	assign wr = req && wb_we_i && ack_r;
	assign evt[pups_pkg::IRQ_PWRUP] = link.pwrupIrq;
	assign evt[pups_pkg::IRQ_RUN] = link.runState && !runPrev_r;

	// Read multiplexer, unmapped offsets read zero
	always_comb begin
		rmux = 32'h0000_0000;
		case (wb_adr_i)
			pups_pkg::WB_CTRL: rmux[1:0] = ctrl_r;
			pups_pkg::WB_CFG: rmux[11:0] = {cfgAddr_r, cfgData_r};
			pups_pkg::WB_STAT: begin
				rmux[pups_pkg::N_OUT-1:0] = link.outEnable;
				rmux[pups_pkg::STAT_RESET] = link.mcuResetN;
				rmux[pups_pkg::STAT_RUN] = link.runState;
				rmux[pups_pkg::STAT_FUSE] = link.fuseLoadDone;
			end
			pups_pkg::WB_IRQ: rmux[pups_pkg::IRQ_W-1:0] = stat_r;
			pups_pkg::WB_MASK: rmux[pups_pkg::IRQ_W-1:0] = mask_r;
			default: rmux = 32'h0000_0000;
		endcase
	end

	// Bus slave and control register next values
	always_comb begin
		ctrl_nxt = ctrl_r;
		cfgWe_nxt = 1'b0;
		cfgAddr_nxt = cfgAddr_r;
		cfgData_nxt = cfgData_r;
		mask_nxt = mask_r;
		ack_nxt = req && !ack_r;
		rdat_nxt = (req && !ack_r) ? rmux : rdat_r;
		stat_nxt = stat_r;
		if (wr && wb_sel_i[0] && wb_adr_i == pups_pkg::WB_CTRL) begin
			ctrl_nxt = wb_dat_i[1:0];
		end
		if (wr && wb_sel_i[1:0] == 2'b11 && wb_adr_i == pups_pkg::WB_CFG) begin
			cfgWe_nxt = 1'b1;
			cfgAddr_nxt = wb_dat_i[pups_pkg::CFG_ADDR_LSB +: 4];
			cfgData_nxt = wb_dat_i[7:0];
		end
		if (wr && wb_sel_i[0] && wb_adr_i == pups_pkg::WB_MASK) begin
			mask_nxt = wb_dat_i[pups_pkg::IRQ_W-1:0];
		end
		if (wr && wb_sel_i[0] && wb_adr_i == pups_pkg::WB_IRQ) begin
			stat_nxt = stat_r & ~wb_dat_i[pups_pkg::IRQ_W-1:0];
		end
		// Set wins over a clear in the same cycle
		stat_nxt = stat_nxt | evt;
	end

	always_ff @(posedge clk) begin
		if (!nrst) begin
			ctrl_r <= 2'h0;
			cfgWe_r <= 1'b0;
			cfgAddr_r <= 4'h0;
			cfgData_r <= 8'h00;
			stat_r <= '0;
			mask_r <= '0;
			ack_r <= 1'b0;
			rdat_r <= 32'h0000_0000;
			runPrev_r <= 1'b0;
		end else begin
			ctrl_r <= ctrl_nxt;
			cfgWe_r <= cfgWe_nxt;
			cfgAddr_r <= cfgAddr_nxt;
			cfgData_r <= cfgData_nxt;
			stat_r <= stat_nxt;
			mask_r <= mask_nxt;
			ack_r <= ack_nxt;
			rdat_r <= rdat_nxt;
			runPrev_r <= link.runState;
		end
	end

	// Outputs
	assign wb_ack_o = ack_r;
	assign wb_dat_o = rdat_r;
	assign irq = |(stat_r & mask_r);
	assign link.powerOnPin = ctrl_r[pups_pkg::CTRL_POWER_ON_PIN];
	assign link.standbyReq = ctrl_r[pups_pkg::CTRL_STBY];
	assign link.cfgWe = cfgWe_r;
	assign link.cfgAddr = cfgAddr_r;
	assign link.cfgWdata = cfgData_r;
endmodule
`default_nettype wire

/* File: pups_props.sv */
`timescale 1ns/1ps
`default_nettype none
module pups_props #(
	parameter int FUSE_CYC = 50,
	parameter int WAKE_CYC = 40
) (
	input wire logic clk,
	input wire logic nrst,
	input wire logic powerOnPin,
	input wire logic standbyReq,
	input wire logic cfgWe,
	input wire logic [3:0] cfgAddr,
	input wire logic [7:0] cfgWdata,
	input wire logic [pups_pkg::N_OUT-1:0] outEnable,
	input wire logic mcuResetN,
	input wire logic runState,
	input wire logic pwrupIrq,
	input wire logic fuseLoadDone
);
	localparam int FUSE_MAX = FUSE_CYC + 4;
	localparam int WAKE_MAX = WAKE_CYC + 2;
	localparam int EXIT_MAX = 100;
	default clocking cb @(posedge clk); endclocking
	default disable iff (!nrst);
	// Fuse load ends in bound and nothing starts before it
	chk_fuse_bound: assert property ($rose(nrst) |-> ##[0:FUSE_MAX] fuseLoadDone)
		else $error("fuse load not done in time");
	chk_no_early_out: assert property (!fuseLoadDone |-> outEnable == '0 && !runState)
		else $error("output before fuse load");
	// A pin rise in off reaches the first slot within the wake bound
	chk_wake_bound: assert property ($rose(powerOnPin) && fuseLoadDone && !runState
		|-> ##[1:WAKE_MAX] (outEnable != '0 || runState))
		else $error("first slot late after pin rise");
	// Enabled outputs stay on while pin is high and no standby is asked
	chk_outs_sticky: assert property (powerOnPin && $past(powerOnPin) && !standbyReq
		&& !$past(standbyReq) |-> (outEnable & $past(outEnable)) == $past(outEnable))
		else $error("enabled output dropped");
	// Pin low in level mode ends up in off with all outputs down
	chk_pin_low_off: assert property (!powerOnPin |-> ##[0:4] (!runState && outEnable == '0))
		else $error("pin low did not reach off");
	// Entering run releases the MCU reset
	chk_run_release: assert property ($rose(runState) |-> ##[0:1] mcuResetN)
		else $error("reset held after run entry");
	// Power-up pulse is one cycle and belongs to run
	chk_irq_pulse: assert property (pwrupIrq |=> !pwrupIrq)
		else $error("power-up pulse too long");
	chk_irq_in_run: assert property (pwrupIrq |-> ##[0:1] runState)
		else $error("power-up pulse outside run");
	// Leaving standby always ends with the power-up pulse
	chk_stby_exit_irq: assert property ($fell(standbyReq) && !runState && powerOnPin
		|-> ##[1:EXIT_MAX] pwrupIrq)
		else $error("no power-up pulse after standby exit");
endmodule
`default_nettype wire

/* File: power_up_sequencer_tb.sv */
`timescale 1ns/1ps
`default_nettype none
module power_up_sequencer_tb;
	localparam int FUSE = 50;
	localparam int WAKE = 40;
	localparam int DBNC = 20;
	localparam int TBC [4] = '{5, 8, 12, 16};
	logic clk;
	logic nrst;
	logic nrst2;
	logic [7:0] adr;
	logic [31:0] wdat;
	logic [31:0] rdat;
	logic [31:0] q;
	logic we;
	logic [3:0] sel;
	logic cyc;
	logic stb;
	logic ack;
	logic irq;
	logic lpo;
	logic [pups_pkg::N_OUT-1:0][7:0] seqF;
	logic [1:0] tbF;
	logic edgeF;
	logic [7:0] vc;
	logic [7:0] wv;
	int fails;
	int n_compared;
	int cycN;
	int tOn [8];
	pups_if lk();
	pups_if lk2();
	pups_host pups_host_i (.clk(clk), .nrst(nrst), .wb_adr_i(adr), .wb_dat_i(wdat),
		.wb_dat_o(rdat), .wb_we_i(we), .wb_sel_i(sel), .wb_cyc_i(cyc), .wb_stb_i(stb),
		.wb_ack_o(ack), .irq(irq), .link(lk.host));
	pups_device #(.FUSE_CYC(FUSE), .WAKE_CYC(WAKE), .DBNC_CYC(DBNC), .TB0_CYC(TBC[0]),
		.TB1_CYC(TBC[1]), .TB2_CYC(TBC[2]), .TB3_CYC(TBC[3])) pups_device_i (.clk(clk),
		.nrst(nrst), .link(lk.dev), .seqFuse(seqF), .tbaseFuse(tbF), .edgeModeFuse(1'b0),
		.ovShdnFuse(vc[6]), .ovloEnable(vc[7]), .supplyOk(vc[5]), .overVoltage(vc[4]),
		.overTemp(vc[3]), .trimFail(vc[2]), .fuseFail(vc[1]), .selftestFail(vc[0]),
		.lowPowerOff(lpo));
	// Spare device driven straight by the bench for validity and edge mode
	pups_device #(.FUSE_CYC(FUSE), .WAKE_CYC(WAKE), .DBNC_CYC(DBNC), .TB0_CYC(TBC[0]),
		.TB1_CYC(TBC[1]), .TB2_CYC(TBC[2]), .TB3_CYC(TBC[3])) pups_device_i2 (.clk(clk),
		.nrst(nrst2), .link(lk2.dev), .seqFuse(seqF), .tbaseFuse(tbF), .edgeModeFuse(edgeF),
		.ovShdnFuse(vc[6]), .ovloEnable(vc[7]), .supplyOk(vc[5]), .overVoltage(vc[4]),
		.overTemp(vc[3]), .trimFail(vc[2]), .fuseFail(vc[1]), .selftestFail(vc[0]),
		.lowPowerOff());
	pups_props #(.FUSE_CYC(FUSE), .WAKE_CYC(WAKE)) pups_props_i (.clk(clk), .nrst(nrst),
		.powerOnPin(lk.powerOnPin), .standbyReq(lk.standbyReq), .cfgWe(lk.cfgWe),
		.cfgAddr(lk.cfgAddr), .cfgWdata(lk.cfgWdata), .outEnable(lk.outEnable),
		.mcuResetN(lk.mcuResetN), .runState(lk.runState), .pwrupIrq(lk.pwrupIrq),
		.fuseLoadDone(lk.fuseLoadDone));
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	// First-rise stamps of outputs, pin and power-up pulse
	assign wv = {lk.pwrupIrq, lk.powerOnPin, lk.outEnable};
	always @(posedge clk) begin
		cycN <= cycN + 1;
		for (int i = 0; i < 8; i++) begin
			if (wv[i] === 1'b1 && tOn[i] < 0) tOn[i] <= cycN;
		end
	end
	task automatic close_out();
		$display("compared %0d, mismatches %0d", n_compared, fails);
		if (fails == 0 && n_compared > 0) begin
			$display("verification passed");
		end else begin
			$display("verification failed");
		end
		$finish;
	endtask
	task automatic check(input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp) begin
			fails++;
			$display("unexpected at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	// Classic single Wishbone cycle, held until ack
	task automatic wb(input logic w, input logic [7:0] a, input logic [31:0] d);
		int n;
		n = 0;
		@(posedge clk);
		cyc <= 1'b1;
		stb <= 1'b1;
		we <= w;
		sel <= 4'hf;
		adr <= a;
		wdat <= d;
		do begin
			@(posedge clk);
			n++;
		end while (ack !== 1'b1 && n < 20);
		if (n >= 20) begin
			fails++;
			close_out();
		end
		q = rdat;
		cyc <= 1'b0;
		stb <= 1'b0;
	endtask
	function automatic logic sig(input int s);
		case (s)
			0: return lk.runState;
			1: return lk.fuseLoadDone;
			2: return lk2.fuseLoadDone;
			4: return !lk.outEnable[1];
			7: return irq;
			default: return !lk.runState;
		endcase
	endfunction
	// Bounded wait on a completion signal
	task automatic await(input int s, input int lim);
		int n;
		n = 0;
		while (sig(s) !== 1'b1) begin
			@(posedge clk);
			n++;
			if (n > lim) begin
				fails++;
				close_out();
			end
		end
	endtask
	task automatic s_boot();
		await(1, FUSE + 4);
		check(lpo, 1'b0);
		wb(1'b0, pups_pkg::WB_STAT, '0);
		check(q[8:0], 9'h100);
	endtask
	// Spare device: each failed condition blocks the event, then edge mode
	task automatic s_valid();
		logic [7:0] cs [8];
		cs = '{8'he1, 8'he2, 8'he4, 8'he8, 8'hf0, 8'hc0, 8'hb0, 8'h70};
		for (int i = 0; i < 8; i++) begin
			vc <= cs[i];
			lk2.powerOnPin <= 1'b1;
			repeat (WAKE + 10) @(posedge clk);
			check(|lk2.outEnable, i > 5);
			lk2.powerOnPin <= 1'b0;
			repeat (10) @(posedge clk);
		end
		vc <= 8'he0;
		edgeF <= 1'b1;
		lk2.powerOnPin <= 1'b1;
		nrst2 <= 1'b0;
		repeat (2) @(posedge clk);
		nrst2 <= 1'b1;
		await(2, FUSE + 4);
		lk2.powerOnPin <= 1'b0;
		repeat (DBNC / 2) @(posedge clk);
		lk2.powerOnPin <= 1'b1;
		repeat (WAKE + DBNC) @(posedge clk);
		check(|lk2.outEnable, 1'b0);
		lk2.powerOnPin <= 1'b0;
		repeat (WAKE + DBNC + 10) @(posedge clk);
		check(|lk2.outEnable, 1'b1);
	endtask
	// Power-up from off on fuse time base k, then a code rewrite that off must undo
	task automatic s_seq(input int k);
		tbF <= k[1:0];
		wb(1'b1, pups_pkg::WB_CTRL, '0);
		await(6, 10);
		tOn = '{default: -1};
		wb(1'b1, pups_pkg::WB_CTRL, 32'h0000_0001);
		await(0, WAKE + 4 * TBC[k] + 20);
		@(posedge clk);
		check(tOn[0] > tOn[6] && tOn[0] - tOn[6] <= WAKE, 1'b1);
		check(tOn[3] - tOn[0], TBC[k]);
		check(tOn[1] - tOn[0], 2 * TBC[k]);
		check(tOn[4] - tOn[0], 3 * TBC[k]);
		check(tOn[2], -1);
		check(tOn[5] >= tOn[4], 1'b1);
		check(lk.outEnable, 6'h3b);
		wb(1'b1, pups_pkg::WB_CFG, 32'h0000_0304);
	endtask
	// Standby exit with a re-enabled regulator, then one with none
	task automatic s_stby();
		logic [5:0] oe;
		int t0;
		wb(1'b1, pups_pkg::WB_CFG, 32'h0000_0603);
		wb(1'b1, pups_pkg::WB_CFG, 32'h0000_080D);
		wb(1'b1, pups_pkg::WB_CFG, 32'h0000_0102);
		wb(1'b1, pups_pkg::WB_MASK, 32'h0000_0001);
		wb(1'b1, pups_pkg::WB_CTRL, 32'h0000_0003);
		await(4, 20);
		tOn = '{default: -1};
		wb(1'b1, pups_pkg::WB_CTRL, 32'h0000_0001);
		t0 = cycN;
		await(7, 100);
		check(tOn[1] - t0 >= TBC[3] && tOn[1] - t0 <= TBC[3] + 8, 1'b1);
		check(tOn[7] >= tOn[1], 1'b1);
		wb(1'b0, pups_pkg::WB_IRQ, '0);
		check(q[0], 1'b1);
		wb(1'b1, pups_pkg::WB_IRQ, 32'h0000_0003);
		@(posedge clk);
		check(irq, 1'b0);
		wb(1'b1, pups_pkg::WB_CFG, 32'h0000_080F);
		wb(1'b1, pups_pkg::WB_CTRL, 32'h0000_0003);
		await(6, 20);
		oe = lk.outEnable;
		tOn[7] = -1;
		wb(1'b1, pups_pkg::WB_CTRL, 32'h0000_0001);
		await(7, 20);
		check(lk.outEnable, oe);
		check(tOn[7] >= 0, 1'b1);
		wb(1'b1, pups_pkg::WB_MASK, '0);
		@(posedge clk);
		check(irq, 1'b0);
		wb(1'b0, 8'h40, '0);
		check(q, '0);
	endtask
	// Low-power bit kept through off, slave-mode start, cleared by power cycle
	task automatic s_slave();
		wb(1'b1, pups_pkg::WB_CFG, 32'h0000_0701);
		repeat (3) @(posedge clk);
		check(lpo, 1'b1);
		seqF <= '0;
		wb(1'b1, pups_pkg::WB_CTRL, '0);
		await(6, 10);
		wb(1'b1, pups_pkg::WB_CTRL, 32'h0000_0001);
		await(0, WAKE);
		@(posedge clk);
		check(lk.outEnable, 6'h20);
		check(lk.mcuResetN, 1'b1);
		check(lpo, 1'b1);
		nrst <= 1'b0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		check(lpo, 1'b0);
		await(1, FUSE + 4);
	endtask
	initial begin
		nrst = 1'b0;
		nrst2 = 1'b0;
		cyc = 1'b0;
		stb = 1'b0;
		we = 1'b0;
		adr = '0;
		wdat = '0;
		sel = 4'hf;
		seqF = 48'h0004_0200_0301;
		tbF = 2'h0;
		edgeF = 1'b0;
		vc = 8'he0;
		fails = 0;
		n_compared = 0;
		cycN = 0;
		tOn = '{default: -1};
		lk2.powerOnPin = 1'b0;
		lk2.standbyReq = 1'b0;
		lk2.cfgWe = 1'b0;
		lk2.cfgAddr = '0;
		lk2.cfgWdata = '0;
		repeat (2) @(posedge clk);
		nrst <= 1'b1;
		nrst2 <= 1'b1;
		s_boot();
		s_valid();
		for (int k = 3; k >= 0; k--) s_seq(k);
		s_stby();
		s_slave();
		close_out();
	end
endmodule
`default_nettype wire
